// ==== logic/wdslp_pkg.sv ====
// Constants, register map and carrier types of the watchdog and sleep controller.
// Assumes a 50 MHz system clock and a classic Wishbone master with 32-bit data.
package wdslp_pkg;

  // Clock and timing
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int WDT_PERIOD_MS = 18;
  localparam int WDT_BASE_CYCLES = WDT_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int WDT_BASE_W = 20;
  localparam int SCALE_W = 7;

  // Register indices; byte address is four times the index
  localparam int ADR_W = 16;
  localparam logic [13:0] IDX_STATUS = 14'h0003;
  localparam logic [13:0] IDX_IRQ_CTRL = 14'h000b;
  localparam logic [13:0] IDX_OPTION = 14'h0081;
  localparam logic [13:0] IDX_CONFIG = 14'h2007;

  // Reset values
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;

  // Field positions
  localparam int CFG_WATCHDOG_FUSE_ENABLE_BIT = 2;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_PS_LSB = 0;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int IC_GIE_BIT = 7;
  localparam int IC_EEIE_BIT = 6;
  localparam int IC_T0IE_BIT = 5;
  localparam int IC_INTE_BIT = 4;
  localparam int IC_RBIE_BIT = 3;

  // Interrupt vector taken after an interrupt wake with global enable set
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  typedef struct packed {
    logic ext_irq;
    logic port_change;
    logic eeprom_done;
    logic timer0;
  } wdslp_irq_flags_t;

  typedef struct packed {
    logic sleep_instr;
    logic kick_watchdog_instr;
  } wdslp_core_ev_t;

  typedef struct packed {
    logic asleep;
    logic main_osc_en;
    logic io_hold;
    logic dev_reset;
    logic wake;
    logic take_vector;
    logic prefetch_next;
  } wdslp_ctl_t;

endpackage

// ==== logic/wdslp_top.sv ====
// Watchdog timer and power-down controller with a Wishbone register slave.
// Assumes core events and interrupt flags are synchronous to clk_i; the main
// oscillator enable output is honoured by the clock generator outside.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
module wdslp_top
  import wdslp_pkg::*;
#(
  parameter int BASE_CYCLES = WDT_BASE_CYCLES
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core and pins
  input wire wdslp_core_ev_t core_ev_i,
  input wire wdslp_irq_flags_t irq_flags_i,
  input wire logic master_reset_pin_n_i,
  input wire logic [7:0] config_word_i,
  // Power and reset control
  output wdslp_ctl_t ctl_o,
  output logic [12:0] vector_addr_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] option;
    logic [7:0] irq_ctrl;
    logic [7:0] cfg;
    logic to_n;
    logic pd_n;
    logic [WDT_BASE_W-1:0] base_cnt;
    logic [SCALE_W-1:0] scale_cnt;
    wdslp_ctl_t ctl;
    logic [12:0] vector;
  } wdslp_state_t;

  localparam logic [WDT_BASE_W-1:0] BASE_LAST = WDT_BASE_W'(BASE_CYCLES - 1);

  wdslp_state_t state_reg;
  wdslp_state_t state_next;

  // Last scaler count for a three-bit ratio field: 1:1 doubling to 1:128
  function automatic logic [SCALE_W-1:0] scale_last(input logic [2:0] ratio);
    scale_last = SCALE_W'((8'h01 << ratio) - 8'h01);
  endfunction

  function automatic logic [31:0] read_reg(input wdslp_state_t s, input logic [13:0] idx);
    read_reg = 32'h0000_0000;
    case (idx)
      IDX_OPTION: read_reg[7:0] = s.option;
      IDX_CONFIG: read_reg[7:0] = s.cfg;
      IDX_IRQ_CTRL: read_reg[7:0] = s.irq_ctrl;
      IDX_STATUS: begin
        read_reg[ST_TO_BIT] = s.to_n;
        read_reg[ST_PD_BIT] = s.pd_n;
      end
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction

  logic [13:0] idx;
  logic wdt_on;
  logic scaler_assign;
  logic base_done;
  logic expire;
  logic wake_req;
  logic global_irq_enable;

  assign idx = wb_adr_i[ADR_W-1:2];
  assign wdt_on = state_reg.cfg[CFG_WATCHDOG_FUSE_ENABLE_BIT];
  assign scaler_assign = state_reg.option[OPT_PSA_BIT];
  assign global_irq_enable = state_reg.irq_ctrl[IC_GIE_BIT];
  assign base_done = wdt_on && (state_reg.base_cnt == BASE_LAST);
  assign expire = base_done && (!scaler_assign || state_reg.scale_cnt == scale_last(state_reg.option[OPT_PS_LSB +: 3]));

  // Timer0 has no enable in this term: its clock stops in sleep.
  assign wake_req = (irq_flags_i.ext_irq && state_reg.irq_ctrl[IC_INTE_BIT])
    || (irq_flags_i.port_change && state_reg.irq_ctrl[IC_RBIE_BIT])
    || (irq_flags_i.eeprom_done && state_reg.irq_ctrl[IC_EEIE_BIT]);

  always_comb begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.ctl.dev_reset = 1'b0;
    state_next.ctl.wake = 1'b0;
    state_next.ctl.take_vector = 1'b0;
    state_next.ctl.prefetch_next = 1'b0;

    // One wait state; ack drops the cycle after it was given
    if (wb_cyc_i && wb_stb_i && !state_reg.ack) begin
      state_next.ack = 1'b1;
      state_next.rdata = read_reg(state_reg, idx);
      if (wb_we_i && wb_sel_i[0]) begin
        case (idx)
          IDX_OPTION: state_next.option = wb_dat_i[7:0];
          IDX_IRQ_CTRL: state_next.irq_ctrl = wb_dat_i[7:0];
          default: state_next.option = state_reg.option;
        endcase
      end
    end

    // Counts on every clk_i edge while the watchdog fuse enable bit is set, whether or not the core sleeps; held at zero otherwise
    if (!wdt_on) begin
      state_next.base_cnt = '0;
      state_next.scale_cnt = '0;
    end else if (base_done) begin
      state_next.base_cnt = '0;
      if (scaler_assign) begin
        state_next.scale_cnt = state_reg.scale_cnt + SCALE_W'(1);
      end
    end else begin
      state_next.base_cnt = state_reg.base_cnt + WDT_BASE_W'(1);
    end

    if (!master_reset_pin_n_i) begin
      // Pin reset wakes by resetting; flags keep the sleep record
      state_next.ctl.dev_reset = 1'b1;
      state_next.ctl.asleep = 1'b0;
    end else if (expire) begin
      state_next.base_cnt = '0;
      state_next.scale_cnt = '0;
      state_next.to_n = 1'b0;
      if (state_reg.ctl.asleep) begin
        state_next.ctl.wake = 1'b1;
        state_next.ctl.asleep = 1'b0;
      end else begin
        // Internal reset only; no pin driver exists here
        state_next.ctl.dev_reset = 1'b1;
        state_next.pd_n = 1'b1;
      end
    end else if (core_ev_i.sleep_instr && !state_reg.ctl.asleep) begin
      state_next.ctl.prefetch_next = 1'b1;
      if (!(wake_req && !global_irq_enable)) begin
        // A pending enabled flag with global off skips sleep entry; only prefetch_next is still pulsed
        state_next.base_cnt = '0;
        state_next.scale_cnt = '0;
        state_next.to_n = 1'b1;
        state_next.pd_n = 1'b0;
        state_next.ctl.asleep = 1'b1;
      end
    end else if (core_ev_i.kick_watchdog_instr) begin
      state_next.base_cnt = '0;
      state_next.scale_cnt = '0;
      state_next.to_n = 1'b1;
      state_next.pd_n = 1'b1;
    end else if (state_reg.ctl.asleep && wake_req) begin
      // Sleep entry already finished the cycle before, so this wake follows it
      state_next.ctl.wake = 1'b1;
      state_next.ctl.asleep = 1'b0;
      state_next.ctl.take_vector = global_irq_enable;
    end

    state_next.ctl.main_osc_en = !state_next.ctl.asleep;
    state_next.ctl.io_hold = state_next.ctl.asleep;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.option <= OPTION_RST;
      state_reg.irq_ctrl <= IRQ_CTRL_RST;
      state_reg.cfg <= config_word_i;
      state_reg.to_n <= 1'b1;
      state_reg.pd_n <= 1'b1;
      state_reg.ctl.main_osc_en <= 1'b1;
      state_reg.vector <= IRQ_VECTOR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign ctl_o = state_reg.ctl;
  assign vector_addr_o = state_reg.vector;

endmodule

// ==== testbench/wdslp_sva.sv ====
// Port-level checker for the watchdog and sleep controller.
// Assumes it is bound into wdslp_top and sees only its ports.
`timescale 1ns/10ps
module wdslp_sva
  import wdslp_pkg::*;
#(
  parameter int BASE_CYCLES = WDT_BASE_CYCLES
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core and control
  input wire wdslp_core_ev_t core_ev_i,
  input wire wdslp_irq_flags_t irq_flags_i,
  input wire logic master_reset_pin_n_i,
  input wire wdslp_ctl_t ctl_o,
  input wire logic [12:0] vector_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_prefetch_next: assert property (core_ev_i.sleep_instr && !ctl_o.asleep && master_reset_pin_n_i |=> ctl_o.prefetch_next)
    else $error("no prefetch after sleep");
  a_osc_off: assert property (ctl_o.asleep |-> !ctl_o.main_osc_en)
    else $error("main oscillator on while asleep");
  a_pins_held: assert property (ctl_o.io_hold == ctl_o.asleep)
    else $error("pin hold differs from sleep state");
  a_wake_resumes: assert property (ctl_o.wake |-> !ctl_o.dev_reset && !ctl_o.asleep && $past(ctl_o.asleep))
    else $error("bad wake");
  a_expiry_awake: assert property (ctl_o.dev_reset && $past(master_reset_pin_n_i) &&
    $past(master_reset_pin_n_i, 2) |-> $past(ctl_o.asleep) == 1'b0) else $error("expiry reset while asleep");
  a_vector_wake: assert property (ctl_o.take_vector |-> ctl_o.wake && vector_addr_o == IRQ_VECTOR)
    else $error("vector without wake");
  a_leave_sleep: assert property ($fell(ctl_o.asleep) |-> ctl_o.wake || ctl_o.dev_reset)
    else $error("sleep left without cause");
  a_sleep_enter: assert property (core_ev_i.sleep_instr && !ctl_o.asleep && master_reset_pin_n_i &&
    irq_flags_i == '0 |=> ctl_o.asleep && !ctl_o.wake) else $error("sleep not entered");
  c_vector: cover property (ctl_o.take_vector);
  c_reset: cover property (ctl_o.dev_reset);
  c_sleep: cover property ($rose(ctl_o.asleep));
endmodule
bind wdslp_top wdslp_sva #(.BASE_CYCLES(BASE_CYCLES)) u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .core_ev_i, .irq_flags_i, .master_reset_pin_n_i, .ctl_o, .vector_addr_o);

// ==== testbench/wdslp_core_model.sv ====
// Core-side model: instruction events and interrupt flags.
// Assumes the bench sets the flags and calls the tasks.
`timescale 1ns/10ps
module wdslp_core_model
  import wdslp_pkg::*;
(
  // System
  input wire logic clk_i,
  // Core outputs
  output wdslp_core_ev_t core_ev_o,
  output wdslp_irq_flags_t irq_flags_o
);
  initial begin
    core_ev_o = '0;
    irq_flags_o = '0;
  end
  task automatic pulse(input logic slp);
    @(posedge clk_i);
    core_ev_o <= {slp, !slp};
    @(posedge clk_i);
    core_ev_o <= '0;
  endtask
  // Flags are owned here so the bench never drives the same net
  task automatic flags(input wdslp_irq_flags_t f);
    @(posedge clk_i);
    irq_flags_o <= f;
  endtask
  // Kick first so the watchdog is known to be clear
  task automatic doze();
    pulse(1'b0);
    pulse(1'b1);
    // Empty slot after sleep stands for the advised nop
    @(posedge clk_i);
  endtask
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the watchdog and sleep controller.
// Assumes a shortened base period so every time-out is short.
`timescale 1ns/10ps
module testbench;
  import wdslp_pkg::*;
  localparam int BASE = 16;
  logic clk_i = 1'b0;
  logic rst_i, cyc, we, pin_n;
  logic [15:0] adr;
  logic [31:0] dat, rd, wb_dat_o;
  logic [7:0] cfg;
  logic [12:0] vec;
  logic wb_ack_o;
  wdslp_ctl_t ctl_o;
  wdslp_core_ev_t ev;
  wdslp_irq_flags_t fl;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  always #10 clk_i = ~clk_i;
  wdslp_core_model core (.clk_i, .core_ev_o(ev), .irq_flags_o(fl));
  wdslp_top #(.BASE_CYCLES(BASE)) uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .core_ev_i(ev),
    .irq_flags_i(fl), .master_reset_pin_n_i(pin_n), .config_word_i(cfg), .ctl_o, .vector_addr_o(vec));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic expire(input int lim);
    n = 0;
    core.pulse(1'b0);
    repeat (lim + 9) if (ctl_o.dev_reset !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk("expiry", n >= lim - 3 && n <= lim + 4, 32'h0000_0001);
  endtask
  task automatic ww(input logic tv);
    repeat (60) if (ctl_o.wake !== 1'b1) @(posedge clk_i);
    chk("wake", ctl_o.wake, 32'h0000_0001);
    chk("vector", ctl_o.take_vector, tv);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rst_i <= 1'b1;
    cyc <= 1'b0;
    we <= 1'b0;
    adr <= 16'h0000;
    dat <= 32'h0000_0000;
    pin_n <= 1'b1;
    cfg <= 8'hff;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(16'h0204, 32'h0000_00ff);
    rc(16'h000c, 32'h0000_0018);
    rc(16'h0100, 32'h0000_0000);
    wb(1'b1, 16'h801c, 8'h00);
    rc(16'h801c, 32'h0000_00ff);
    for (int r = 0; r < 8; r++) begin
      wb(1'b1, 16'h0204, {5'h01, r[2:0]});
      expire(BASE << r);
    end
    wb(1'b1, 16'h0204, 8'h00);
    expire(BASE);
    rc(16'h000c, 32'h0000_0008);
    wb(1'b1, 16'h0204, 8'h0f);
    wb(1'b1, 16'h002c, 8'hb0);
    core.flags(4'h1);
    core.doze();
    @(posedge clk_i);
    chk("asleep", ctl_o.asleep, 32'h0000_0001);
    rc(16'h000c, 32'h0000_0010);
    core.flags(4'h9);
    ww(1'b1);
    wb(1'b1, 16'h002c, 8'h10);
    core.flags(4'h8);
    core.doze();
    @(posedge clk_i);
    chk("nop", ctl_o.asleep, 32'h0000_0000);
    rc(16'h000c, 32'h0000_0018);
    core.flags(4'h0);
    core.doze();
    core.flags(4'h8);
    ww(1'b0);
    core.flags(4'h0);
    core.doze();
    pin_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("pin reset", {ctl_o.dev_reset, ctl_o.asleep}, 32'h0000_0002);
    pin_n <= 1'b1;
    wb(1'b1, 16'h0204, 8'h00);
    core.doze();
    ww(1'b0);
    rc(16'h000c, 32'h0000_0000);
    cfg <= 8'h00;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 16'h0204, 8'h00);
    n = 0;
    repeat (100) begin
      @(posedge clk_i);
      if (ctl_o.dev_reset !== 1'b0) n++;
    end
    chk("disabled", n, 32'h0000_0000);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end
endmodule
